// ==== rtl/sfb_pkg.sv ====
package sfb_pkg;

	// timing
	localparam int CLK_PERIOD_NS  = 100;
	localparam int RESET_TIME_NS  = 1000;
	localparam int RESET_CYC      = (RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RST_CNT_W      = 4;

	// dummy clocks after the address of each fast read
	localparam logic [3:0] DUMMY_FAST = 4'h8;
	localparam logic [3:0] DUMMY_DIO  = 4'h4;
	localparam logic [3:0] DUMMY_QIO  = 4'h6;

	// address lengths in bits
	localparam logic [5:0] ALEN_3B    = 6'h18;
	localparam logic [5:0] ALEN_4B    = 6'h20;

	// opcodes
	localparam logic [7:0] OP_WRSR    = 8'h01;
	localparam logic [7:0] OP_PP      = 8'h02;
	localparam logic [7:0] OP_READ    = 8'h03;
	localparam logic [7:0] OP_RDSR    = 8'h05;
	localparam logic [7:0] OP_FAST    = 8'h0B;
	localparam logic [7:0] OP_FAST4   = 8'h0C;
	localparam logic [7:0] OP_PP4     = 8'h12;
	localparam logic [7:0] OP_READ4   = 8'h13;
	localparam logic [7:0] OP_DOUT    = 8'h3B;
	localparam logic [7:0] OP_DOUT4   = 8'h3C;
	localparam logic [7:0] OP_QOUT    = 8'h6B;
	localparam logic [7:0] OP_QOUT4   = 8'h6C;
	localparam logic [7:0] OP_ENTER4  = 8'hB7;
	localparam logic [7:0] OP_DIO     = 8'hBB;
	localparam logic [7:0] OP_DIO4    = 8'hBC;
	localparam logic [7:0] OP_EXIT4   = 8'hE9;
	localparam logic [7:0] OP_QIO     = 8'hEB;
	localparam logic [7:0] OP_QIO4    = 8'hEC;

	typedef enum logic [2:0] {
		ST_WAIT, ST_CMD, ST_ADDR, ST_DUMMY, ST_READ, ST_WRITE, ST_IGNORE
	} sfb_state_e;

	typedef enum logic [2:0] {
		K_NONE, K_READ, K_WRITE, K_WRSR, K_RDSR, K_ENTER4, K_EXIT4
	} sfb_kind_e;

endpackage : sfb_pkg

// ==== rtl/sfb_front_end.sv ====
`timescale 1ns/1ps
module sfb_front_end (
	// system
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic        clk_en,
	// pins
	input  wire logic        sclk_pin,
	input  wire logic        chip_select_low,
	input  wire logic        reset_pin_n,
	input  wire logic [3:0]  dl_in,
	output logic      [3:0]  dl_out,
	output logic      [3:0]  dl_oe,
	// core side
	input  wire logic        quad_enable_bit,
	input  wire logic        status_protect_bit,
	input  wire logic        powerup_addr_len_bit,
	input  wire logic [7:0]  ext_addr_reg,
	input  wire logic        busy_in,
	input  wire logic [7:0]  rd_data,
	output logic      [7:0]  cmd_op,
	output logic             cmd_valid,
	output logic      [31:0] addr,
	output logic             addr_valid,
	output logic             rd_req,
	output logic      [7:0]  wr_data,
	output logic             wr_valid,
	output logic             current_addr_len_bit,
	output logic             status_write_blocked,
	output logic             paused,
	output logic             hw_reset
);
	logic                 sclk_s1, sclk_s2, sclk_s3, cs_s1, cs_s2, cs_s3, rp_s1, rp_s2;
	logic [3:0]           dl_s1, dl_s2;
	logic [sfb_pkg::RST_CNT_W-1:0] rp_cnt_r;
	logic                 abort, held, sel, pause_act, rise_ev, fall_ev, cs_rise;
	logic                 armed_r, init_r, addr4_r, full4_r;
	sfb_pkg::sfb_state_e  state_r;
	sfb_pkg::sfb_kind_e   kind_r, dkind;
	logic [31:0]          sh_r, sh_nxt;
	logic [5:0]           bit_cnt_r, alen;
	logic [2:0]           in_lanes_r, out_lanes_r, dlanes, dout;
	logic [3:0]           dummy_r, ddummy, dcnt_r;
	logic [7:0]           nxt_op, oshift_r, obyte;
	logic [3:0]           obits_r;
	logic                 d4b;

	// two flops on every pin, a third on sclk and chip select for edge detection
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			{sclk_s1, sclk_s2, sclk_s3} <= 3'h0;
			{cs_s1, cs_s2, cs_s3}       <= 3'h7;
			{rp_s1, rp_s2}              <= 2'h3;
			dl_s1                       <= 4'hF;
			dl_s2                       <= 4'hF;
		end else if (clk_en) begin
			sclk_s1 <= sclk_pin;
			sclk_s2 <= sclk_s1;
			sclk_s3 <= sclk_s2;
			cs_s1   <= chip_select_low;
			cs_s2   <= cs_s1;
			cs_s3   <= cs_s2;
			rp_s1   <= reset_pin_n;
			rp_s2   <= rp_s1;
			dl_s1   <= dl_in;
			dl_s2   <= dl_s1;
		end
	end

	// reset pin must stay low the full time before it counts
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rp_cnt_r <= '0;
			hw_reset <= 1'b0;
		end else if (clk_en) begin
			hw_reset <= abort && rp_cnt_r == sfb_pkg::RST_CNT_W'(sfb_pkg::RESET_CYC - 1);
			if (rp_s2)
				rp_cnt_r <= '0;
			else if (!held)
				rp_cnt_r <= rp_cnt_r + 1'b1;
		end
	end

	assign held      = rp_cnt_r == sfb_pkg::RST_CNT_W'(sfb_pkg::RESET_CYC);
	assign abort     = !rp_s2 && rp_cnt_r >= sfb_pkg::RST_CNT_W'(sfb_pkg::RESET_CYC - 1);
	assign sel       = !cs_s2;
	assign cs_rise   = cs_s2 && !cs_s3;
	assign pause_act = sel && !dl_s2[3] && !quad_enable_bit;
	// clock edges counted only while selected, so idle level is free
	assign rise_ev   = sel && !pause_act && sclk_s2 && !sclk_s3;
	assign fall_ev   = sel && !pause_act && !sclk_s2 && sclk_s3;
	assign nxt_op    = {sh_r[6:0], dl_s2[0]};

	always_comb begin
		case (in_lanes_r)
			3'h2:    sh_nxt = {sh_r[29:0], dl_s2[1:0]};
			3'h4:    sh_nxt = {sh_r[27:0], dl_s2[3:0]};
			default: sh_nxt = {sh_r[30:0], dl_s2[0]};
		endcase
	end

	// opcode decode
	always_comb begin
		dkind  = sfb_pkg::K_NONE;
		dlanes = 3'h1;
		dout   = 3'h1;
		ddummy = 4'h0;
		d4b    = 1'b0;
		case (nxt_op)
			sfb_pkg::OP_READ:   dkind = sfb_pkg::K_READ;
			sfb_pkg::OP_READ4:  begin dkind = sfb_pkg::K_READ; d4b = 1'b1; end
			sfb_pkg::OP_FAST, sfb_pkg::OP_FAST4: begin
				dkind = sfb_pkg::K_READ; ddummy = sfb_pkg::DUMMY_FAST; d4b = nxt_op[0] == 1'b0;
			end
			sfb_pkg::OP_DOUT, sfb_pkg::OP_DOUT4: begin
				dkind = sfb_pkg::K_READ; ddummy = sfb_pkg::DUMMY_FAST; dout = 3'h2;
				d4b = nxt_op[0] == 1'b0;
			end
			sfb_pkg::OP_DIO, sfb_pkg::OP_DIO4: begin
				dkind = sfb_pkg::K_READ; ddummy = sfb_pkg::DUMMY_DIO; dout = 3'h2; dlanes = 3'h2;
				d4b = nxt_op[0] == 1'b0;
			end
			sfb_pkg::OP_QOUT, sfb_pkg::OP_QOUT4: begin
				dkind = quad_enable_bit ? sfb_pkg::K_READ : sfb_pkg::K_NONE;
				ddummy = sfb_pkg::DUMMY_FAST; dout = 3'h4; d4b = nxt_op[0] == 1'b0;
			end
			sfb_pkg::OP_QIO, sfb_pkg::OP_QIO4: begin
				dkind = quad_enable_bit ? sfb_pkg::K_READ : sfb_pkg::K_NONE;
				ddummy = sfb_pkg::DUMMY_QIO; dout = 3'h4; dlanes = 3'h4;
				d4b = nxt_op[0] == 1'b0;
			end
			sfb_pkg::OP_PP:     dkind = sfb_pkg::K_WRITE;
			sfb_pkg::OP_PP4:    begin dkind = sfb_pkg::K_WRITE; d4b = 1'b1; end
			sfb_pkg::OP_WRSR:   dkind = sfb_pkg::K_WRSR;
			sfb_pkg::OP_RDSR:   dkind = sfb_pkg::K_RDSR;
			sfb_pkg::OP_ENTER4: dkind = sfb_pkg::K_ENTER4;
			sfb_pkg::OP_EXIT4:  dkind = sfb_pkg::K_EXIT4;
			default:            dkind = sfb_pkg::K_NONE;
		endcase
	end

	assign alen = (addr4_r || full4_r) ? sfb_pkg::ALEN_4B : sfb_pkg::ALEN_3B;

	// address mode and the power-on arming
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			init_r  <= 1'b0;
			addr4_r <= 1'b0;
			armed_r <= 1'b0;
		end else if (clk_en) begin
			if (abort || !init_r) begin
				init_r  <= 1'b1;
				addr4_r <= powerup_addr_len_bit;
				armed_r <= 1'b0;
			end else begin
				if (cs_s2)
					armed_r <= 1'b1;
				if (state_r == sfb_pkg::ST_CMD && rise_ev && bit_cnt_r == 6'h7
						&& !busy_in) begin
					if (dkind == sfb_pkg::K_ENTER4)
						addr4_r <= 1'b1;
					else if (dkind == sfb_pkg::K_EXIT4)
						addr4_r <= 1'b0;
				end
			end
		end
	end

	// command framing
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_r     <= sfb_pkg::ST_WAIT;
			kind_r      <= sfb_pkg::K_NONE;
			sh_r        <= '0;
			bit_cnt_r   <= '0;
			in_lanes_r  <= 3'h1;
			out_lanes_r <= 3'h1;
			dummy_r     <= '0;
			dcnt_r      <= '0;
			full4_r     <= 1'b0;
			cmd_op      <= '0;
			cmd_valid   <= 1'b0;
			addr        <= '0;
			addr_valid  <= 1'b0;
			wr_data     <= '0;
			wr_valid    <= 1'b0;
		end else if (clk_en) begin
			cmd_valid  <= 1'b0;
			addr_valid <= 1'b0;
			wr_valid   <= 1'b0;
			if (abort) begin
				state_r <= sfb_pkg::ST_WAIT;
			end else if (cs_rise || cs_s2) begin
				// busy_in cycles are not touched, only the frame ends
				state_r <= sfb_pkg::ST_WAIT;
			end else if (state_r == sfb_pkg::ST_WAIT) begin
				if (armed_r && cs_s3) begin
					state_r    <= sfb_pkg::ST_CMD;
					bit_cnt_r  <= '0;
					in_lanes_r <= 3'h1;
				end
			end else if (rise_ev) begin
				sh_r <= sh_nxt;
				case (state_r)
					sfb_pkg::ST_CMD: begin
						bit_cnt_r <= bit_cnt_r + 6'h1;
						if (bit_cnt_r == 6'h7) begin
							cmd_op      <= nxt_op;
							cmd_valid   <= 1'b1;
							kind_r      <= dkind;
							full4_r     <= d4b;
							in_lanes_r  <= dlanes;
							out_lanes_r <= dout;
							dummy_r     <= ddummy;
							bit_cnt_r   <= '0;
							if (busy_in && dkind != sfb_pkg::K_RDSR)
								state_r <= sfb_pkg::ST_IGNORE;
							else if (dkind == sfb_pkg::K_READ || dkind == sfb_pkg::K_WRITE)
								state_r <= sfb_pkg::ST_ADDR;
							else if (dkind == sfb_pkg::K_RDSR)
								state_r <= sfb_pkg::ST_READ;
							else if (dkind == sfb_pkg::K_WRSR && !status_write_blocked)
								state_r <= sfb_pkg::ST_WRITE;
							else
								state_r <= sfb_pkg::ST_IGNORE;
						end
					end
					sfb_pkg::ST_ADDR: begin
						bit_cnt_r <= bit_cnt_r + 6'(in_lanes_r);
						if (bit_cnt_r + 6'(in_lanes_r) == alen) begin
							addr_valid <= 1'b1;
							bit_cnt_r  <= '0;
							in_lanes_r <= 3'h1;
							dcnt_r     <= '0;
							if (alen == sfb_pkg::ALEN_4B)
								addr <= sh_nxt;
							else
								addr <= {ext_addr_reg, sh_nxt[23:0]};
							if (kind_r == sfb_pkg::K_WRITE)
								state_r <= sfb_pkg::ST_WRITE;
							else if (dummy_r != 4'h0)
								state_r <= sfb_pkg::ST_DUMMY;
							else
								state_r <= sfb_pkg::ST_READ;
						end
					end
					sfb_pkg::ST_DUMMY: begin
						dcnt_r <= dcnt_r + 4'h1;
						if (dcnt_r == dummy_r - 4'h1)
							state_r <= sfb_pkg::ST_READ;
					end
					sfb_pkg::ST_WRITE: begin
						bit_cnt_r <= bit_cnt_r + 6'h1;
						if (bit_cnt_r == 6'h7) begin
							wr_data   <= sh_nxt[7:0];
							wr_valid  <= 1'b1;
							bit_cnt_r <= '0;
						end
					end
					default: ;
				endcase
			end
		end
	end

	assign obyte = (obits_r == 4'h0) ? rd_data : oshift_r;

	// read data leaves on falling edges
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			oshift_r <= '0;
			obits_r  <= '0;
			dl_out   <= '0;
			dl_oe    <= '0;
			rd_req   <= 1'b0;
			paused   <= 1'b0;
		end else if (clk_en) begin
			rd_req <= 1'b0;
			paused <= pause_act && !abort;
			if (abort || state_r != sfb_pkg::ST_READ) begin
				obits_r <= '0;
				dl_oe   <= '0;
			end else begin
				if (!sel || pause_act || cs_rise)
					dl_oe <= '0;
				else
					case (out_lanes_r)
						3'h2:    dl_oe <= 4'h3;
						3'h4:    dl_oe <= 4'hF;
						default: dl_oe <= 4'h2;
					endcase
				if (fall_ev) begin
					rd_req <= obits_r == 4'h0;
					case (out_lanes_r)
						3'h2: begin
							dl_out   <= {2'h0, obyte[7:6]};
							oshift_r <= {obyte[5:0], 2'h0};
						end
						3'h4: begin
							dl_out   <= obyte[7:4];
							oshift_r <= {obyte[3:0], 4'h0};
						end
						default: begin
							dl_out   <= {2'h0, obyte[7], 1'b0};
							oshift_r <= {obyte[6:0], 1'b0};
						end
					endcase
					obits_r <= ((obits_r == 4'h0) ? 4'h8 : obits_r) - 4'(out_lanes_r);
				end
			end
		end
	end

	// status outputs
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			current_addr_len_bit <= 1'b0;
			status_write_blocked <= 1'b0;
		end else if (clk_en) begin
			current_addr_len_bit <= addr4_r;
			status_write_blocked <= status_protect_bit && !dl_s2[2] && !quad_enable_bit;
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n || !clk_en);

	property p_desel_float;
		cs_s2 && $past(cs_s2) |=> dl_oe == 4'h0;
	endproperty
	a_desel_float: assert property (p_desel_float) else $error("lanes driven while deselected");

	property p_no_cmd_unarmed;
		!armed_r |-> ##[1:8] !cmd_valid;
	endproperty
	a_no_cmd_unarmed: assert property (p_no_cmd_unarmed) else $error("command before select edge");

	property p_pause_float;
		pause_act && $past(pause_act) |=> dl_oe == 4'h0 && paused;
	endproperty
	a_pause_float: assert property (p_pause_float) else $error("output live during pause");

	property p_qe_no_pause;
		quad_enable_bit |-> !pause_act;
	endproperty
	a_qe_no_pause: assert property (p_qe_no_pause) else $error("pause active with quad enabled");

	property p_reset_abort;
		$rose(hw_reset) |-> state_r == sfb_pkg::ST_WAIT ##1 (!armed_r && dl_oe == 4'h0);
	endproperty
	a_reset_abort: assert property (p_reset_abort) else $error("reset pin did not abort");

	property p_enter4;
		cmd_valid && cmd_op == sfb_pkg::OP_ENTER4 && kind_r == sfb_pkg::K_ENTER4
			|=> current_addr_len_bit;
	endproperty
	a_enter4: assert property (p_enter4) else $error("enter four-byte ignored");

	property p_alen_status;
		##1 current_addr_len_bit == $past(addr4_r);
	endproperty
	a_alen_status: assert property (p_alen_status) else $error("address length bit stale");

	property p_ext_addr;
		addr_valid && !$past(addr4_r) && !full4_r |-> addr[31:24] == $past(ext_addr_reg);
	endproperty
	a_ext_addr: assert property (p_ext_addr) else $error("extended address not applied");

	property p_out_on_fall;
		state_r == sfb_pkg::ST_READ && $changed(dl_out) |-> $past(fall_ev);
	endproperty
	a_out_on_fall: assert property (p_out_on_fall) else $error("output moved off falling edge");

	c_read:   cover property (addr_valid ##[1:300] rd_req);
	c_enter4: cover property ($rose(current_addr_len_bit));
	c_pause:  cover property ($rose(paused));
	c_reset:  cover property ($rose(hw_reset));

endmodule : sfb_front_end

// ==== test/sfb_host_model.sv ====
`timescale 1ns/1ps
module sfb_host_model (
	// pins
	output logic		sclk,
	output logic		cs_n,
	output logic		rpin_n,
	output logic [3:0]	h_out,
	output logic [3:0]	h_oe,
	// resolved lanes
	input  wire logic [3:0]	dl
);
	localparam int HALF = 400;
	logic [3:0]	d_r;
	logic [3:0]	e_r;
	logic		q_r;
	logic		wp;
	logic		hold;
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		rpin_n = 1'b1;
		{d_r, e_r, q_r} = '0;
		{wp, hold} = 2'b11;
	end
	// guard and pause pins stay driven unless lanes go four wide
	assign h_out = q_r ? d_r : {hold, wp, d_r[1:0]};
	assign h_oe = q_r ? e_r : {2'b11, e_r[1:0]};
	task automatic start(input bit m3);
		sclk = m3;
		#30;
		cs_n = 1'b0;
		#HALF;
	endtask : start
	task automatic xfer(input int n, input int ln, input bit drv, input logic [31:0] v,
			output logic [31:0] got);
		logic [3:0] m;
		m = 4'((1 << ln) - 1);
		got = '0;
		for (int i = n - 1; i >= 0; i--) begin
			sclk = 1'b0;
			q_r = (ln == 4);
			d_r = 4'(v >> (i * ln)) & m;
			e_r = drv ? m : 4'h0;
			#HALF;
			sclk = 1'b1;
			got = (got << ln) | 32'((ln == 1) ? 4'(dl[1]) : dl & m);
			#HALF;
		end
	endtask : xfer
	task automatic stop(input bit m3);
		sclk = m3;
		e_r = 4'h0;
		q_r = 1'b0;
		#HALF;
		cs_n = 1'b1;
		#(2 * HALF);
	endtask : stop
	task automatic rst_pin(input int ns);
		rpin_n = 1'b0;
		#ns;
		rpin_n = 1'b1;
		#HALF;
	endtask : rst_pin
endmodule : sfb_host_model

// ==== test/tb_sfb_front_end.sv ====
`timescale 1ns/1ps
module tb_sfb_front_end;
	logic		clock = 1'b0;
	logic		rst_n = 1'b0;
	logic		qe = 1'b0;
	logic		sp = 1'b0;
	logic		padl = 1'b1;
	logic		flt = 1'b0;
	logic		busy = 1'b0;
	logic [7:0]	ext = 8'h5A;
	logic [7:0]	rdd = 8'hA5;
	logic		sclk, cs_n, rpin_n;
	logic [3:0]	dl_out, dl_oe, h_out, h_oe, dl;
	logic [7:0]	op, wr_data;
	logic [31:0]	addr, rx;
	logic		cmd_v, addr_v, rd_req, wr_v, cur, blk, paused, hw_rst;
	int		err_count = 0;
	int		checks = 0;
	int		n_a = 0;
	int		n_w = 0;
	int		n_r = 0;
	int		cyc = 0;
	always #50 clock = ~clock;
	// lanes nobody drives show a toggling level
	assign dl = (dl_oe & dl_out) | (~dl_oe & h_oe & h_out) | (~dl_oe & ~h_oe & {4{flt}});
	sfb_front_end DUT (.clock(clock), .rst_n(rst_n), .clk_en(1'b1), .sclk_pin(sclk),
		.chip_select_low(cs_n), .reset_pin_n(rpin_n), .dl_in(dl), .dl_out(dl_out),
		.dl_oe(dl_oe), .quad_enable_bit(qe), .status_protect_bit(sp),
		.powerup_addr_len_bit(padl), .ext_addr_reg(ext), .busy_in(busy),
		.rd_data(rdd), .cmd_op(op), .cmd_valid(cmd_v), .addr(addr), .addr_valid(addr_v),
		.rd_req(rd_req), .wr_data(wr_data), .wr_valid(wr_v), .current_addr_len_bit(cur),
		.status_write_blocked(blk), .paused(paused), .hw_reset(hw_rst));
	sfb_host_model u_host (.sclk(sclk), .cs_n(cs_n), .rpin_n(rpin_n), .h_out(h_out),
		.h_oe(h_oe), .dl(dl));
	always @(posedge clock) begin
		flt <= ~flt;
		cyc <= cyc + 1;
		if (addr_v === 1'b1) n_a <= n_a + 1;
		if (wr_v === 1'b1) n_w <= n_w + 1;
		if (hw_rst === 1'b1) n_r <= n_r + 1;
		if (cyc == 40000) begin
			err_count++;
			finish_test();
		end
	end
	task automatic finish_test();
		if (err_count == 0 && checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : finish_test
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic wt(input int n);
		repeat (n) @(posedge clock);
	endtask : wt
	task automatic cfg(input logic q, input logic s, input logic p);
		@(posedge clock);
		qe <= q;
		sp <= s;
		padl <= p;
		wt(3);
	endtask : cfg
	task automatic cmd(input logic [7:0] c);
		u_host.start(0);
		u_host.xfer(8, 1, 1, 32'(c), rx);
		u_host.stop(0);
	endtask : cmd
	// frame is left open so the caller can look at the lanes
	task automatic rd(input bit m3, input logic [7:0] c, input int an, input int al,
			input logic [31:0] a, input int dm, input int rl, input int e);
		int n0;
		n0 = n_a;
		u_host.start(m3);
		u_host.xfer(8, 1, 1, 32'(c), rx);
		u_host.xfer(an / al, al, 1, a, rx);
		u_host.xfer(dm, rl, 0, 0, rx);
		u_host.xfer(8 / rl, rl, 0, 0, rx);
		chk(n_a - n0, e);
	endtask : rd
	task automatic fast(input logic [7:0] c, input int al, input logic [3:0] dm,
			input int rl, input logic [3:0] oe);
		rd(0, c, 24, al, 32'h00C0DE, int'(dm), rl, 1);
		chk(addr, 32'h5A00C0DE);
		chk(rx[7:0], 8'hA5);
		chk(dl_oe, oe);
		u_host.stop(0);
	endtask : fast
	task automatic wr(input int e);
		int n0;
		n0 = n_w;
		u_host.start(0);
		u_host.xfer(16, 1, 1, {sfb_pkg::OP_WRSR, 8'h3C}, rx);
		u_host.stop(0);
		chk(n_w - n0, e);
		if (e == 1) chk(wr_data, 8'h3C);
	endtask : wr
	task automatic t_modes();
		wt(4);
		chk(cur, 1);
		chk(dl_oe, 0);
		cmd(sfb_pkg::OP_EXIT4);
		chk(cur, 0);
		rd(0, sfb_pkg::OP_READ, 24, 1, 32'h123456, 0, 1, 1);
		chk(addr, 32'h5A123456);
		chk(rx[7:0], 8'hA5);
		chk(dl_oe, 4'h2);
		u_host.stop(0);
		wt(6);
		chk(dl_oe, 0);
		rd(1, sfb_pkg::OP_READ4, 32, 1, 32'hFEDCBA98, 0, 1, 1);
		chk(addr, 32'hFEDCBA98);
		u_host.stop(1);
		cmd(sfb_pkg::OP_ENTER4);
		chk(cur, 1);
		rd(1, sfb_pkg::OP_READ, 32, 1, 32'h01234567, 0, 1, 1);
		chk(addr, 32'h01234567);
		chk(rx[7:0], 8'hA5);
		u_host.stop(1);
		cmd(sfb_pkg::OP_EXIT4);
	endtask : t_modes
	task automatic t_lanes();
		fast(sfb_pkg::OP_DOUT, 1, sfb_pkg::DUMMY_FAST, 2, 4'h3);
		fast(sfb_pkg::OP_DIO, 2, sfb_pkg::DUMMY_DIO, 2, 4'h3);
		rd(0, sfb_pkg::OP_QOUT, 24, 1, 0, 8, 4, 0);
		chk(dl_oe, 0);
		u_host.stop(0);
		cfg(1, 0, 1);
		fast(sfb_pkg::OP_QOUT, 1, sfb_pkg::DUMMY_FAST, 4, 4'hF);
		fast(sfb_pkg::OP_QIO, 4, sfb_pkg::DUMMY_QIO, 4, 4'hF);
	endtask : t_lanes
	task automatic t_guard();
		cfg(0, 1, 1);
		u_host.wp = 1'b0;
		wt(6);
		chk(blk, 1);
		wr(0);
		u_host.wp = 1'b1;
		wt(6);
		chk(blk, 0);
		wr(1);
	endtask : t_guard
	task automatic t_pause();
		cfg(0, 0, 1);
		rd(0, sfb_pkg::OP_READ, 24, 1, 0, 0, 1, 1);
		u_host.hold = 1'b0;
		wt(6);
		chk({paused, dl_oe}, 5'h10);
		u_host.hold = 1'b1;
		wt(6);
		chk({paused, dl_oe}, 5'h02);
		u_host.stop(0);
		cfg(1, 0, 1);
		u_host.start(0);
		u_host.hold = 1'b0;
		wt(6);
		chk(paused, 0);
		u_host.hold = 1'b1;
		u_host.stop(0);
	endtask : t_pause
	task automatic t_reset();
		int n0;
		cfg(0, 0, 0);
		cmd(sfb_pkg::OP_ENTER4);
		n0 = n_r;
		rd(0, sfb_pkg::OP_READ, 32, 1, 0, 0, 1, 1);
		u_host.rst_pin(500);
		chk(n_r - n0, 0);
		chk(dl_oe, 4'h2);
		u_host.rst_pin(1100);
		wt(4);
		chk(n_r - n0, 1);
		chk({cur, dl_oe}, 0);
		u_host.stop(0);
	endtask : t_reset
	task automatic t_busy();
		@(posedge clock);
		busy <= 1'b1;
		rd(0, sfb_pkg::OP_READ, 24, 1, 0, 0, 1, 0);
		chk(op, sfb_pkg::OP_READ);
		chk(dl_oe, 0);
		u_host.stop(0);
		@(posedge clock);
		busy <= 1'b0;
		ext <= 8'h33;
		rdd <= 8'h96;
		rd(0, sfb_pkg::OP_READ, 24, 1, 32'h0ABCDE, 0, 1, 1);
		chk(addr, 32'h330ABCDE);
		chk(rx[7:0], 8'h96);
		u_host.stop(0);
	endtask : t_busy
	initial begin
		wt(16);
		rst_n <= 1'b1;
		t_modes();
		t_lanes();
		t_guard();
		t_pause();
		t_reset();
		t_busy();
		finish_test();
	end
endmodule : tb_sfb_front_end
